// ==== hw/brake_pkg.sv ====
package brake_pkg;
   // ==================================================
   // Timing
   // ==================================================
   localparam int CLK_HZ          = 100_000_000; // System clock rate
   localparam int TICK_MS         = 1;           // Delay resolution, ms
   localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS; // Cycles per ms
   // ==================================================
   // Delay settings
   // ==================================================
   localparam int DELAY_W         = 14;          // Holds 0..10000
   localparam int DELAY_MAX_MS    = 10000;       // Largest legal setting
   localparam logic [13:0] RELEASE_DELAY_RST = 14'h0000; // Reset value
   localparam logic [13:0] OFF_DELAY_RST     = 14'h0000; // Reset value
   // ==================================================
   // Output routing
   // ==================================================
   localparam int OUT_CHANNELS    = 8;           // General outputs
   localparam int SEL_W           = 3;           // Channel select width
   localparam logic [2:0] BRAKE_SEL_RST = 3'h3;  // Default channel three
   // Sequencer states
   typedef enum logic [2:0] {
      ST_OFF, ST_WAIT_RELEASE, ST_RUN, ST_WAIT_OFF
   } seq_state_t;
endpackage

// ==== hw/ms_tick_if.sv ====
`timescale 1ns/1ns
// Millisecond tick carried from divider to sequencer
interface ms_tick_if;
   logic tick;   // One-cycle pulse each ms
   logic clear;  // Restart the divider phase
   modport src (input clear, output tick);
   modport dst (input tick, output clear);
endinterface

// ==== hw/ms_divider.sv ====
`timescale 1ns/1ns
// ==================================================
// Millisecond enable divider
// ==================================================
module ms_divider
   import brake_pkg::*;
#(
   parameter int CYCLES = TICK_CYCLES
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Tick out
   ms_tick_if.src   tk
);
   localparam int CW = $clog2(CYCLES);
   logic [CW-1:0] count;       // Cycles since last tick
   logic [CW-1:0] next_count;
   logic          next_tick;

   initial begin
      if (CYCLES < 2) $error("CYCLES must be at least 2");
   end

   // Count cycles, pulse on wrap; clear restarts a whole ms
   always_comb begin
      next_tick  = 1'b0;
      next_count = count + CW'(1);
      if (tk.clear) begin
         next_count = '0;
      end else if (count == CW'(CYCLES - 1)) begin
         next_count = '0;
         next_tick  = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         count   <= '0;
         tk.tick <= 1'b0;
      end else begin
         count   <= next_count;
         tk.tick <= next_tick;
      end
   end
endmodule

// ==== hw/brake_release_sequencer.sv ====
`timescale 1ns/1ns
// Contract
// - Brake on chosen output, default channel three
// - Release brake after programmable delay, default zero
// - Never release before or with servo-ON
// - On withdrawal engage brake, delay actual off
// - Accept delay settings only in servo-OFF
module brake_release_sequencer
   import brake_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
) (
   // Clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  rstn,
   // Host command (pin, synchronised here)
   input  wire logic                  servo_on_command,
   // Settings
   input  wire logic                  cfg_write,
   input  wire logic [DELAY_W-1:0]    cfg_release_delay,
   input  wire logic [DELAY_W-1:0]    cfg_off_delay,
   input  wire logic [SEL_W-1:0]      cfg_brake_sel,
   // Status and drive
   output logic                       servo_energised,
   output logic                       cfg_accepted,
   output logic [OUT_CHANNELS-1:0]    brake_control_output
);
   import brake_pkg::*;

   // ==================================================
   // Elaboration checks
   // ==================================================
   initial begin
      if (TICK_CYC < 2) $error("TICK_CYC must be at least 2");
   end

   // ==================================================
   // Input synchroniser
   // ==================================================
   logic cmd_meta;   // First stage, read only by second
   logic cmd_sync;   // Safe command level

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         cmd_meta <= 1'b0;
         cmd_sync <= 1'b0;
      end else begin
         cmd_meta <= servo_on_command;
         cmd_sync <= cmd_meta;
      end
   end

   // ==================================================
   // Millisecond tick
   // ==================================================
   ms_tick_if tk ();

   ms_divider #(.CYCLES(TICK_CYC)) u_div (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .tk      (tk)
   );

   // ==================================================
   // Settings
   // ==================================================
   logic [DELAY_W-1:0] release_delay;  // Held release delay, ms
   logic [DELAY_W-1:0] off_delay;      // Held servo-off delay, ms
   logic [SEL_W-1:0]   brake_sel;      // Output channel for brake
   logic [DELAY_W-1:0] next_release_delay;
   logic [DELAY_W-1:0] next_off_delay;
   logic [SEL_W-1:0]   next_brake_sel;
   logic               next_cfg_accepted;
   logic               in_off;         // Sequencer idle in servo-OFF

   // Clamp out-of-range settings to the largest legal value
   function automatic logic [DELAY_W-1:0] clamp_ms(
      input logic [DELAY_W-1:0] v
   );
      if (v > DELAY_W'(DELAY_MAX_MS))
         return DELAY_W'(DELAY_MAX_MS);
      return v;
   endfunction

   // Writes outside servo-OFF are dropped, not queued
   always_comb begin
      next_release_delay = release_delay;
      next_off_delay     = off_delay;
      next_brake_sel     = brake_sel;
      next_cfg_accepted  = 1'b0;
      if (cfg_write && in_off) begin
         next_release_delay = clamp_ms(cfg_release_delay);
         next_off_delay     = clamp_ms(cfg_off_delay);
         next_brake_sel     = cfg_brake_sel;
         next_cfg_accepted  = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         release_delay <= RELEASE_DELAY_RST;
         off_delay     <= OFF_DELAY_RST;
         brake_sel     <= BRAKE_SEL_RST;
         cfg_accepted  <= 1'b0;
      end else begin
         release_delay <= next_release_delay;
         off_delay     <= next_off_delay;
         brake_sel     <= next_brake_sel;
         cfg_accepted  <= next_cfg_accepted;
      end
   end

   // ==================================================
   // Sequencer
   // ==================================================
   seq_state_t         state;          // Present sequence step
   seq_state_t         next_state;
   logic [DELAY_W-1:0] ms_left;        // Remaining ms of current delay
   logic [DELAY_W-1:0] next_ms_left;
   logic               next_energised;
   logic               brake_release;  // Brake released level
   logic               next_release;

   assign in_off = (state == ST_OFF);

   // Energise first; brake released only from ST_RUN onward
   always_comb begin
      next_state     = state;
      next_ms_left   = ms_left;
      next_energised = servo_energised;
      next_release   = 1'b0;
      tk.clear       = 1'b0;
      unique case (state)
         ST_OFF: begin
            next_energised = 1'b0;
            if (cmd_sync) begin
               // Energise now; release waits at least one cycle
               next_energised = 1'b1;
               next_ms_left   = release_delay;
               next_state     = ST_WAIT_RELEASE;
               tk.clear       = 1'b1;
            end
         end
         ST_WAIT_RELEASE: begin
            if (!cmd_sync) begin
               // Abandon countdown, brake never released
               next_ms_left = off_delay;
               next_state   = ST_WAIT_OFF;
               tk.clear     = 1'b1;
            end else if (ms_left == '0) begin
               next_release = 1'b1;
               next_state   = ST_RUN;
            end else if (tk.tick) begin
               next_ms_left = ms_left - DELAY_W'(1);
            end
         end
         ST_RUN: begin
            next_release = 1'b1;
            if (!cmd_sync) begin
               // Brake engages in the same step as withdrawal
               next_release = 1'b0;
               next_ms_left = off_delay;
               next_state   = ST_WAIT_OFF;
               tk.clear     = 1'b1;
            end
         end
         ST_WAIT_OFF: begin
            // Motor held energised while brake takes hold
            if (ms_left == '0) begin
               next_energised = 1'b0;
               next_state     = ST_OFF;
            end else if (tk.tick) begin
               next_ms_left = ms_left - DELAY_W'(1);
            end
         end
         default: begin
            next_state     = ST_OFF;
            next_energised = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state           <= ST_OFF;
         ms_left         <= '0;
         servo_energised <= 1'b0;
         brake_release   <= 1'b0;
      end else begin
         state           <= next_state;
         ms_left         <= next_ms_left;
         servo_energised <= next_energised;
         brake_release   <= next_release;
      end
   end

   // ==================================================
   // Output routing
   // ==================================================
   // A one-cycle lag behind brake_release keeps outputs flop-driven
   logic [OUT_CHANNELS-1:0] next_outputs;

   always_comb begin
      next_outputs = '0;
      for (int i = 0; i < OUT_CHANNELS; i++) begin
         next_outputs[i] = brake_release &&
                           (brake_sel == SEL_W'(i));
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         brake_control_output <= '0;
      end else begin
         brake_control_output <= next_outputs;
      end
   end
endmodule

// ==== tb/brake_seq_chk_sva.sv ====
`timescale 1ns/1ns
// ====
// Pin checks for the brake sequencer
module brake_seq_chk #(parameter int TICK_CYC = 4) (
   // Clock and reset
   input wire logic                          sys_clk,
   input wire logic                          rstn,
   // Host side
   input wire logic                          servo_on_command,
   input wire logic                          cfg_write,
   input wire logic [brake_pkg::DELAY_W-1:0] cfg_release_delay,
   input wire logic [brake_pkg::DELAY_W-1:0] cfg_off_delay,
   input wire logic [brake_pkg::SEL_W-1:0]   cfg_brake_sel,
   // Drive side
   input wire logic                          servo_energised,
   input wire logic                          cfg_accepted,
   input wire logic [7:0]                    brake_control_output
);
   import brake_pkg::*;
   int               rel;  // Shadow release delay, ms
   int               off;  // Shadow off delay, ms
   int               on_c; // Cycles energised
   int               lo_c; // Cycles energised with command low
   logic [SEL_W-1:0] sel;  // Shadow channel
   // Shadow only writes made in servo-OFF
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         sel <= BRAKE_SEL_RST;
         rel <= int'(RELEASE_DELAY_RST);
         off <= int'(OFF_DELAY_RST);
      end else if (cfg_write && !servo_energised) begin
         sel <= cfg_brake_sel;
         rel <= int'(cfg_release_delay);
         off <= int'(cfg_off_delay);
      end
      on_c <= servo_energised ? on_c + 1 : 0;
      lo_c <= (servo_on_command || !servo_energised) ? 0 : lo_c + 1;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   chk_one_channel: assert property ($onehot0(brake_control_output))
      else $error("brake on several channels");
   chk_chosen_channel: assert property (
      |brake_control_output |-> brake_control_output[sel])
      else $error("brake on wrong channel");
   chk_release_after_on: assert property (
      $rose(|brake_control_output) |-> $past(servo_energised))
      else $error("release before servo-on");
   chk_release_delay: assert property (
      $rose(|brake_control_output)
      |-> on_c inside {[rel*TICK_CYC+1:rel*TICK_CYC+5]})
      else $error("release delay wrong");
   chk_drop_engage: assert property (
      !servo_on_command [*5] |-> brake_control_output == '0)
      else $error("brake not engaged");
   chk_off_delay: assert property (
      $fell(servo_energised)
      |-> lo_c inside {[off*TICK_CYC+2:off*TICK_CYC+7]})
      else $error("off delay wrong");
   chk_accept_off: assert property (
      cfg_accepted |-> $past(cfg_write) && !$past(servo_energised))
      else $error("write taken while on");
   chk_write_taken: assert property (
      cfg_write && !servo_energised |=> cfg_accepted)
      else $error("write lost");
   chk_energise_soon: assert property (
      $rose(servo_on_command) && !servo_energised |-> ##[2:4] servo_energised)
      else $error("servo-on not taken");
   cover property ($rose(|brake_control_output));
   cover property ($fell(servo_energised) && off > 0);
   cover property (cfg_accepted);
endmodule
bind brake_release_sequencer brake_seq_chk #(.TICK_CYC(TICK_CYC)) i_chk (
   .sys_clk(sys_clk), .rstn(rstn), .servo_on_command(servo_on_command),
   .cfg_write(cfg_write), .cfg_release_delay(cfg_release_delay),
   .cfg_off_delay(cfg_off_delay), .cfg_brake_sel(cfg_brake_sel),
   .servo_energised(servo_energised), .cfg_accepted(cfg_accepted),
   .brake_control_output(brake_control_output));

// ==== tb/host_model.sv ====
`timescale 1ns/1ns
// ====
// Host controller, changes its lines at the falling edge
module host_model (
   // Clock
   input  wire logic                          sys_clk,
   // Requests from the bench
   input  wire logic                          want_on,
   input  wire logic                          want_write,
   input  wire logic [brake_pkg::SEL_W-1:0]   want_sel,
   input  wire logic [brake_pkg::DELAY_W-1:0] want_rel,
   input  wire logic [brake_pkg::DELAY_W-1:0] want_off,
   // Command and settings
   output logic                               servo_on_command,
   output logic                               cfg_write,
   output logic [brake_pkg::DELAY_W-1:0]      cfg_release_delay,
   output logic [brake_pkg::DELAY_W-1:0]      cfg_off_delay,
   output logic [brake_pkg::SEL_W-1:0]        cfg_brake_sel
);
   // ==================================================
   // Command and settings lines
   // ==================================================
   // Requests set at one falling edge show on the lines at the next,
   // so the block's inputs never move near its sampling edge
   always @(negedge sys_clk) begin
      servo_on_command <= want_on;
      cfg_write        <= want_write;
      if (want_write) begin
         // Settings stand with the strobe
         {cfg_brake_sel, cfg_release_delay, cfg_off_delay} <=
            {want_sel, want_rel, want_off};
      end else begin
         // Idle lines show the inverse, never a stale copy
         {cfg_brake_sel, cfg_release_delay, cfg_off_delay} <=
            ~{want_sel, want_rel, want_off};
      end
   end
endmodule

// ==== tb/brake_release_sequencer_tb.sv ====
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
$display("unexpected %s exp %h got %h", n, e, g); end end
// ====
// Host drives; a monitor checks each output change against a note
module brake_release_sequencer_tb;
   import brake_pkg::*;
   logic              sys_clk, rstn, cmd, wr, acc, en, run;
   logic [13:0]       rel, off;
   logic [2:0]        sel;
   logic [7:0]        bco;
   logic [9:0]        exp_q[$]; // Notes: {accepted, energised, outputs}
   logic [9:0]        prev, e;
   logic [31:0]       seed;
   int                failures, checks;
   logic              want_on, want_write; // Requests to the host
   logic [13:0]       want_rel, want_off;
   logic [2:0]        want_sel;
   host_model i_host_model (.sys_clk(sys_clk), .want_on(want_on),
      .want_write(want_write), .want_sel(want_sel), .want_rel(want_rel),
      .want_off(want_off), .servo_on_command(cmd),
      .cfg_write(wr), .cfg_release_delay(rel), .cfg_off_delay(off),
      .cfg_brake_sel(sel));
   brake_release_sequencer #(.TICK_CYC(4)) i_brake_release_sequencer (
      .sys_clk(sys_clk), .rstn(rstn), .servo_on_command(cmd),
      .cfg_write(wr), .cfg_release_delay(rel), .cfg_off_delay(off),
      .cfg_brake_sel(sel), .servo_energised(en), .cfg_accepted(acc),
      .brake_control_output(bco));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   // Any change with no note left is a spare change
   always @(negedge sys_clk) begin
      if (run && {acc, en, bco} !== prev) begin
         e = exp_q.size() != 0 ? exp_q.pop_front() : 10'h3FF;
         `CHK("outputs", e, {acc, en, bco})
      end
      prev = {acc, en, bco};
   end
   // Settings write; meant for servo-OFF, a test may still try it while on
   task automatic setup(input logic [2:0] s, input logic [13:0] r, o);
      @(negedge sys_clk);
      {want_sel, want_rel, want_off} <= {s, r, o};
      want_write <= 1'b1;
      @(negedge sys_clk);
      want_write <= 1'b0;
   endtask
   task automatic command(input logic v);
      @(negedge sys_clk);
      want_on <= v;
   endtask
   task automatic print_verdict;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Bounded wait for all notes, then a quiet spell
   task automatic settle;
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < 400) begin
         @(negedge sys_clk);
         n++;
      end
      if (exp_q.size() != 0) begin
         failures++;
         $display("unexpected notes_left exp 0 got %0d", exp_q.size());
         print_verdict();
      end
      repeat (12) @(negedge sys_clk);
   endtask
   task automatic write_ok(input logic [2:0] s, input logic [13:0] r, o);
      exp_q.push_back(10'h200);
      exp_q.push_back(10'h000);
      setup(s, r, o);
      settle();
   endtask
   // On, a refused write while running, then off
   task automatic on_off(input logic [2:0] s, input int o);
      exp_q.push_back(10'h100);
      exp_q.push_back({2'b01, 8'(1) << s});
      command(1'b1);
      settle();
      setup(~s, 14'h0000, 14'h0000);
      settle();
      if (o != 0) exp_q.push_back(10'h100);
      exp_q.push_back(10'h000);
      command(1'b0);
      settle();
      $display("test on_off channel %0d done", s);
   endtask
   initial begin
      {rstn, run, prev, failures, checks} = '0;
      {want_on, want_write, want_sel, want_rel, want_off} = '0;
      seed = 32'hB36114D9;
      repeat (4) @(negedge sys_clk);
      rstn = 1'b1;
      run = 1'b1;
      on_off(3'h3, 0);
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         write_ok(seed[2:0], 14'(seed[9:8]), 14'(seed[17:16]));
         on_off(seed[2:0], int'(seed[17:16]));
      end
      // Withdrawal during the release wait
      write_ok(3'h6, 14'd20, 14'h0000);
      exp_q.push_back(10'h100);
      command(1'b1);
      settle();
      exp_q.push_back(10'h000);
      command(1'b0);
      settle();
      $display("test cancel done");
      // Reset while released restores channel three
      write_ok(3'h5, 14'h0001, 14'h0002);
      exp_q.push_back(10'h100);
      exp_q.push_back(10'h120);
      command(1'b1);
      settle();
      exp_q.push_back(10'h000);
      rstn = 1'b0;
      command(1'b0);
      repeat (3) @(negedge sys_clk);
      rstn = 1'b1;
      on_off(3'h3, 0);
      $display("test reset done");
      print_verdict();
   end
endmodule
